// ==== design/cwfd_config_decode.sv ====
`default_nettype none
// What this block does
// R1: word one bit 4 picks watchdog prescale: set gives 1:128, clear 1:32.
// R2: word one bits 3..0 pick postscale of two to the code, 1:1 to 1:32768.
// R3: watchdog timeout applies prescale then postscale in series.
// R4: word two bit 15 enables two-speed start-up; clear disables it.
// R5: word two bits 14..12 pick pll input divide 12, 8, 6, 5 or 4.
// R6: word two bits 23..16 read back as all ones.
// R7: watchdog runs only while word one enable bit is set.
module cwfd_config_decode (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [cwfd_pkg::CWFD_WORD_W-1:0] cfg_word_one_in,
    input wire logic [cwfd_pkg::CWFD_WORD_W-1:0] cfg_word_two_in,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic wdt_config_enable,
    output logic wdt_prescale_select,
    output logic [3:0] wdt_postscale_select,
    output logic [4:0] wdt_timeout_log2,
    output logic two_speed_startup_enable,
    output logic [2:0] pll_input_divider_select,
    output logic [3:0] pll_input_divide,
    output logic config_loaded
);
    import cwfd_pkg::*;

    // ***********************************************
    // state
    // ***********************************************
    logic [23:0] word_one_q, word_one_d;
    logic [23:0] word_two_q, word_two_d;
    logic pend_q, pend_d;
    logic loaded_q, loaded_d;
    logic wdt_en_q, wdt_en_d;
    logic pre_sel_q, pre_sel_d;
    logic [3:0] post_q, post_d;
    logic [4:0] tmo_q, tmo_d;
    logic tss_q, tss_d;
    logic [2:0] pll_code_q, pll_code_d;
    logic [3:0] pll_div_q, pll_div_d;
    logic [31:0] rdata_q, rdata_d;

    logic setup_ph, access_ph, addr_ok, reload_wr;
    logic [31:0] word_one_rd, word_two_rd, decode_rd;

    function automatic logic [3:0] pll_ratio(input logic [2:0] code);
        logic [3:0] r;
        r = CWFD_PLL_DIV_UNDEF;
        case (code)
            CWFD_PLL_CODE_DIV12: r = CWFD_PLL_DIV12; // [R5]
            CWFD_PLL_CODE_DIV8: r = CWFD_PLL_DIV8; // [R5]
            CWFD_PLL_CODE_DIV6: r = CWFD_PLL_DIV6; // [R5]
            CWFD_PLL_CODE_DIV5: r = CWFD_PLL_DIV5; // [R5]
            CWFD_PLL_CODE_DIV4: r = CWFD_PLL_DIV4; // [R5]
            default: r = CWFD_PLL_DIV_UNDEF;
        endcase
        return r;
    endfunction

    // ***********************************************
    // apb decode
    // ***********************************************
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable;
    always_comb begin
        if (paddr == CWFD_OFS_WORD_ONE) begin
            addr_ok = !pwrite;
        end else if (paddr == CWFD_OFS_WORD_TWO) begin
            addr_ok = !pwrite;
        end else if (paddr == CWFD_OFS_DECODE) begin
            addr_ok = !pwrite;
        end else if (paddr == CWFD_OFS_CTRL) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end
    assign reload_wr = access_ph && pwrite && (paddr == CWFD_OFS_CTRL)
        && pwdata[CWFD_CTRL_RELOAD_BIT];
    assign pready = 1'b1;
    assign pslverr = access_ph && !addr_ok;

    assign word_one_rd = {8'h00, CWFD_W1_UPPER_READ, word_one_q[CWFD_UPPER_LSB-1:0]};
    // unimplemented upper byte forced to ones
    assign word_two_rd = {8'h00, CWFD_W2_UPPER_READ, word_two_q[CWFD_UPPER_LSB-1:0]}; // [R6]
    assign decode_rd = {12'h000, loaded_q, pll_div_q, pll_code_q, tss_q,
        tmo_q, post_q, pre_sel_q, wdt_en_q};

    // ***********************************************
    // capture and decode
    // ***********************************************
    always_comb begin
        word_one_d = word_one_q;
        word_two_d = word_two_q;
        pend_d = pend_q;
        loaded_d = loaded_q;
        if (pend_q) begin
            word_one_d = cfg_word_one_in;
            word_two_d = cfg_word_two_in;
            pend_d = 1'b0;
            loaded_d = 1'b1;
        end else if (reload_wr) begin
            pend_d = 1'b1;
        end
        wdt_en_d = word_one_d[CWFD_W1_WDT_EN_BIT]; // [R7]
        pre_sel_d = word_one_d[CWFD_W1_PRESCALE_BIT]; // [R1]
        post_d = word_one_d[CWFD_W1_POSTSCALE_LSB +: CWFD_POSTSCALE_W]; // [R2]
        // prescale then postscale: log2 ratios add
        tmo_d = (pre_sel_d ? CWFD_PRESCALE_LOG2_HI : CWFD_PRESCALE_LOG2_LO)
            + {1'b0, post_d}; // [R1] [R2] [R3]
        tss_d = word_two_d[CWFD_W2_TSS_BIT]; // [R4]
        pll_code_d = word_two_d[CWFD_W2_PLL_INPUT_DIVIDER_SELECT_LSB +: CWFD_PLL_INPUT_DIVIDER_SELECT_W]; // [R5]
        pll_div_d = pll_ratio(pll_code_d); // [R5]
    end

    always_comb begin
        rdata_d = rdata_q;
        if (setup_ph) begin
            if (paddr == CWFD_OFS_WORD_ONE) begin
                rdata_d = word_one_rd;
            end else if (paddr == CWFD_OFS_WORD_TWO) begin
                rdata_d = word_two_rd;
            end else if (paddr == CWFD_OFS_DECODE) begin
                rdata_d = decode_rd;
            end else begin
                rdata_d = 32'h00000000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word_one_q <= CWFD_WORD_RESET;
            word_two_q <= CWFD_WORD_RESET;
            pend_q <= 1'b1;
            loaded_q <= 1'b0;
            wdt_en_q <= 1'b0;
            pre_sel_q <= 1'b0;
            post_q <= 4'h0;
            tmo_q <= 5'h00;
            tss_q <= 1'b0;
            pll_code_q <= 3'h0;
            pll_div_q <= CWFD_PLL_DIV_UNDEF;
            rdata_q <= 32'h00000000;
        end else begin
            word_one_q <= word_one_d;
            word_two_q <= word_two_d;
            pend_q <= pend_d;
            loaded_q <= loaded_d;
            wdt_en_q <= wdt_en_d;
            pre_sel_q <= pre_sel_d;
            post_q <= post_d;
            tmo_q <= tmo_d;
            tss_q <= tss_d;
            pll_code_q <= pll_code_d;
            pll_div_q <= pll_div_d;
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
    assign wdt_config_enable = wdt_en_q && loaded_q; // [R7]
    assign wdt_prescale_select = pre_sel_q;
    assign wdt_postscale_select = post_q;
    assign wdt_timeout_log2 = tmo_q;
    assign two_speed_startup_enable = tss_q;
    assign pll_input_divider_select = pll_code_q;
    assign pll_input_divide = pll_div_q;
    assign config_loaded = loaded_q;

    // ***********************************************
    // checks
    // ***********************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_prescale_ratio: assert property (loaded_q |->
        (tmo_q - {1'b0, post_q}) == (word_one_q[4] ? 5'h07 : 5'h05)) // [R1]
        else $error("prescale ratio wrong");
    a_postscale_field: assert property (pend_q |=> post_q == $past(cfg_word_one_in[3:0])) // [R2]
        else $error("postscale not captured");
    a_timeout_series: assert property (loaded_q |->
        tmo_q == (pre_sel_q ? 5'h07 : 5'h05) + {1'b0, post_q}) // [R3]
        else $error("timeout not prescale plus postscale");
    a_tss_bit: assert property (pend_q |=> tss_q == $past(cfg_word_two_in[15])) // [R4]
        else $error("two speed start-up wrong");
    a_pll_div12: assert property (loaded_q && pll_code_q == 3'h7 |-> pll_div_q == 4'hc) // [R5]
        else $error("pll divide 12 wrong");
    a_pll_div4: assert property (loaded_q && pll_code_q == 3'h3 |-> pll_div_q == 4'h4) // [R5]
        else $error("pll divide 4 wrong");
    a_upper_ones: assert property (setup_ph && paddr == 8'h04 |=> prdata[23:16] == 8'hff) // [R6]
        else $error("word two upper bits not ones");
    a_wdt_gate: assert property (wdt_config_enable |-> word_one_q[7] && loaded_q) // [R7]
        else $error("watchdog enabled without bit");
    a_reload_seq: assert property (reload_wr && !pend_q |=> pend_q ##1 !pend_q && loaded_q)
        else $error("reload did not recapture");

    c_read_word_two: cover property (setup_ph && paddr == 8'h04 ##1 access_ph);
    c_reload: cover property (reload_wr ##2 loaded_q);
    c_max_timeout: cover property (tmo_q == 5'h16);
    c_bad_addr: cover property (pslverr);
endmodule
`default_nettype wire

// ==== design/cwfd_pkg.sv ====
`default_nettype none
package cwfd_pkg;
    // ***********************************************
    // register map
    // ***********************************************
    localparam logic [7:0] CWFD_OFS_WORD_ONE = 8'h00;
    localparam logic [7:0] CWFD_OFS_WORD_TWO = 8'h04;
    localparam logic [7:0] CWFD_OFS_DECODE = 8'h08;
    localparam logic [7:0] CWFD_OFS_CTRL = 8'h0c;
    // ***********************************************
    // word one fields
    // ***********************************************
    localparam int CWFD_W1_WDT_EN_BIT = 7;
    localparam int CWFD_W1_PRESCALE_BIT = 4;
    localparam int CWFD_W1_POSTSCALE_LSB = 0;
    localparam int CWFD_POSTSCALE_W = 4;
    localparam logic [4:0] CWFD_PRESCALE_LOG2_HI = 5'h07;
    localparam logic [4:0] CWFD_PRESCALE_LOG2_LO = 5'h05;
    // ***********************************************
    // word two fields
    // ***********************************************
    localparam int CWFD_W2_TSS_BIT = 15;
    localparam int CWFD_W2_PLL_INPUT_DIVIDER_SELECT_LSB = 12;
    localparam int CWFD_PLL_INPUT_DIVIDER_SELECT_W = 3;
    localparam int CWFD_WORD_W = 24;
    localparam int CWFD_UPPER_LSB = 16;
    localparam logic [7:0] CWFD_W2_UPPER_READ = 8'hff;
    localparam logic [7:0] CWFD_W1_UPPER_READ = 8'h00;
    // pll input divider codes and ratios
    localparam logic [2:0] CWFD_PLL_CODE_DIV12 = 3'h7;
    localparam logic [2:0] CWFD_PLL_CODE_DIV8 = 3'h6;
    localparam logic [2:0] CWFD_PLL_CODE_DIV6 = 3'h5;
    localparam logic [2:0] CWFD_PLL_CODE_DIV5 = 3'h4;
    localparam logic [2:0] CWFD_PLL_CODE_DIV4 = 3'h3;
    localparam logic [3:0] CWFD_PLL_DIV12 = 4'hc;
    localparam logic [3:0] CWFD_PLL_DIV8 = 4'h8;
    localparam logic [3:0] CWFD_PLL_DIV6 = 4'h6;
    localparam logic [3:0] CWFD_PLL_DIV5 = 4'h5;
    localparam logic [3:0] CWFD_PLL_DIV4 = 4'h4;
    localparam logic [3:0] CWFD_PLL_DIV_UNDEF = 4'h1;
    // control register
    localparam int CWFD_CTRL_RELOAD_BIT = 0;
    // reset values
    localparam logic [23:0] CWFD_WORD_RESET = 24'h000000;
endpackage
`default_nettype wire

// ==== verification/tb_top.sv ====
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [23:0] cfg_word_one_in, cfg_word_two_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic wdt_config_enable, wdt_prescale_select, two_speed_startup_enable, config_loaded;
    logic [3:0] wdt_postscale_select, pll_input_divide;
    logic [4:0] wdt_timeout_log2;
    logic [2:0] pll_input_divider_select;
    int n_mismatch = 0;
    int num_checks = 0;
    cwfd_config_decode u_dut (.pclk(pclk), .presetn(presetn),
        .cfg_word_one_in(cfg_word_one_in), .cfg_word_two_in(cfg_word_two_in),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_config_enable(wdt_config_enable), .wdt_prescale_select(wdt_prescale_select),
        .wdt_postscale_select(wdt_postscale_select), .wdt_timeout_log2(wdt_timeout_log2),
        .two_speed_startup_enable(two_speed_startup_enable),
        .pll_input_divider_select(pll_input_divider_select),
        .pll_input_divide(pll_input_divide), .config_loaded(config_loaded));
    // ***********************************************
    // bus and comparison helpers
    // ***********************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 8) begin
            n_mismatch++;
            test_done();
        end
    endtask
    function automatic logic [3:0] pdiv(input logic [2:0] c);
        case (c)
            3'h7: pdiv = 4'hc;
            3'h6: pdiv = 4'h8;
            3'h5: pdiv = 4'h6;
            3'h4: pdiv = 4'h5;
            3'h3: pdiv = 4'h4;
            default: pdiv = 4'h1;
        endcase
    endfunction
    task automatic chk(input logic [23:0] w1, input logic [23:0] w2);
        logic [31:0] r;
        logic e;
        `CHK("wdt_en", w1[7], wdt_config_enable)
        `CHK("prescale", w1[4], wdt_prescale_select)
        `CHK("postscale", w1[3:0], wdt_postscale_select)
        `CHK("timeout", (w1[4] ? 5'h07 : 5'h05) + {1'b0, w1[3:0]}, wdt_timeout_log2)
        `CHK("tss", w2[15], two_speed_startup_enable)
        `CHK("pll_sel", w2[14:12], pll_input_divider_select)
        `CHK("pll_div", pdiv(w2[14:12]), pll_input_divide)
        apb(1'b0, 8'h00, 32'h0, r, e);
        `CHK("word_one", {16'h0000, w1[15:0]}, r)
        apb(1'b0, 8'h04, 32'h0, r, e);
        `CHK("word_two", {8'h00, 8'hff, w2[15:0]}, r)
        `CHK("rd_err", 1'b0, e)
        apb(1'b0, 8'h08, 32'h0, r, e);
        `CHK("decode", {12'h000, 1'b1, pdiv(w2[14:12]), w2[14:12], w2[15],
            5'((w1[4] ? 5'h07 : 5'h05) + {1'b0, w1[3:0]}), w1[3:0], w1[4], w1[7]}, r)
    endtask
    task automatic load(input logic [23:0] w1, input logic [23:0] w2);
        logic [31:0] r;
        logic e;
        cfg_word_one_in <= w1;
        cfg_word_two_in <= w2;
        apb(1'b1, 8'h0c, 32'h1, r, e);
        `CHK("reload_err", 1'b0, e)
        repeat (3) @(posedge pclk);
        chk(w1, w2);
    endtask
    // ***********************************************
    // scenarios
    // ***********************************************
    task automatic t_reset();
        chk(24'hff_5a_9b, 24'h00_f3_c6);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        `CHK("rst_loaded", 1'b0, config_loaded)
        `CHK("rst_wdt", 1'b0, wdt_config_enable)
        `CHK("rst_div", 4'h1, pll_input_divide)
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        `CHK("loaded", 1'b1, config_loaded)
        chk(24'hff_5a_9b, 24'h00_f3_c6);
        $display("t_reset done");
    endtask
    task automatic t_codes();
        logic [3:0] c;
        for (int k = 0; k < 16; k++) begin
            c = 4'(k);
            load({8'hff, 8'h3c ^ {4'h0, c}, c[0], 2'b01, c[1], c},
                {8'h00, c[3], c[2:0], 12'h5a0 ^ {8'h00, c}});
        end
        $display("t_codes done");
    endtask
    task automatic t_refuse();
        logic [31:0] r;
        logic e;
        load(24'h00_00_8f, 24'h00_f0_00);
        apb(1'b1, 8'h00, 32'h0, r, e);
        `CHK("wr_ro_err", 1'b1, e)
        apb(1'b1, 8'h04, 32'h0, r, e);
        `CHK("wr_ro2_err", 1'b1, e)
        apb(1'b0, 8'h10, 32'h0, r, e);
        `CHK("unmapped_err", 1'b1, e)
        chk(24'h00_00_8f, 24'h00_f0_00);
        $display("t_refuse done");
    endtask
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cfg_word_one_in = 24'hff_5a_9b;
        cfg_word_two_in = 24'h00_f3_c6;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (3) @(posedge pclk);
        t_reset();
        t_codes();
        t_refuse();
        test_done();
    end
endmodule
`default_nettype wire
